// *** mcg_top.v ***
// Behaviour
// R1: Insertion seen when presence input falls high to low by default.
// R2: Presence polarity defaults to low-inserted; control bit selects high.
// R3: Second slot set as embedded card is not run as external slot.
// R4: Each slot drives clock, active-low reset and one bidirectional data.
// R5: Low radio-disable means airplane; low positioning-disable stops GNSS.
// R6: Host wake driven low on enabled SMS, de-registration or voice event.
// R7: Active power-reduce input lowers transmit power when enabled.
// R8: Each general pin takes input, output, fast shutdown or alternate role.
// R9: Input role reports only the current synchronised pin level.
// R10: Output role level is settable and the driven level readable.
// R11: Output role drives both levels push-pull.
// R12: All pin inputs pass two flip-flops before edge or level use.
`timescale 1ns/100ps
`include "mcg_regs.vh"

module mcg_top #(
  parameter GP_N = 9,
  parameter CARD_CLK_DIV = 4,
  parameter DIV_W = 8
) (
  input wire core_clk,
  input wire reset,
  input wire [`MCG_AW-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  output wire irq_out,
  input wire card1_present_in,
  input wire card2_present_in,
  output wire card1_clock_out,
  output wire card2_clock_out,
  output wire card1_reset_out_n,
  output wire card2_reset_out_n,
  input wire card1_data_in,
  output wire card1_data_out,
  output wire card1_data_oe,
  input wire card2_data_in,
  output wire card2_data_out,
  output wire card2_data_oe,
  input wire card1_tx_low,
  input wire card2_tx_low,
  output wire card1_rx_data,
  output wire card2_rx_data,
  input wire radio_disable_in_n,
  input wire positioning_disable_in_n,
  output wire airplane_mode,
  output wire positioning_off,
  input wire power_reduce_in,
  output wire tx_power_reduce,
  input wire evt_sms,
  input wire evt_dereg,
  input wire evt_voice,
  output wire host_wake_out_n,
  input wire [GP_N-1:0] gp_in,
  output wire [GP_N-1:0] gp_out,
  output wire [GP_N-1:0] gp_oe,
  input wire [GP_N-1:0] gp_alt_out,
  input wire [GP_N-1:0] gp_alt_oe,
  output wire [GP_N-1:0] gp_alt_in,
  output wire fast_shutdown
);

  // Role of one general pin out of the packed mode word
  function [1:0] gp_role;
    input [2*GP_N-1:0] modes;
    input integer idx;
    begin
      gp_role = modes[2*idx +: 2];
    end
  endfunction

  localparam SW = `MCG_SI_GP + GP_N;

  reg [`MCG_CTRL_W-1:0] ctrl_q;
  reg [`MCG_WAKE_W-1:0] wake_en_q;
  reg [`MCG_EV_W-1:0] stat_q, stat_d, mask_q;
  reg [2*GP_N-1:0] gp_mode_q;
  reg [GP_N-1:0] gp_level_q;
  reg [31:0] rdata_q, rdata_d;
  reg irq_q, wake_n_q, airplane_q, gnss_off_q, dpr_q, fsd_q, tick_q;
  reg [SW-1:0] sync1_q, sync2_q;
  reg [1:0] ins_prev_q;
  reg [DIV_W-1:0] div_q;

  wire [SW-1:0] raw_in;
  wire [1:0] pres_s, data_s, slot_act, ins_now, tx_low, ins_ev, rem_ev;
  wire [`MCG_WAKE_W-1:0] wake_hits;
  wire [`MCG_EV_W-1:0] events;
  wire [`MCG_PS_W-1:0] pin_stat;
  wire [GP_N-1:0] gp_s, gp_out_w, gp_oe_w, fsd_hit;
  wire [1:0] clk_w, rst_w, dout_w, doe_w, rx_w;
  wire wr_ctrl, wr_stat;

  // All asynchronous pin inputs in one vector for the synchroniser
  assign raw_in = {gp_in, card2_data_in, card1_data_in, power_reduce_in,
                   positioning_disable_in_n, radio_disable_in_n,
                   card2_present_in, card1_present_in};

  // Two-stage synchroniser; only the second stage is used downstream
  always @(posedge core_clk) begin
    if (reset) begin
      sync1_q <= {SW{`MCG_IDLE}};
      sync2_q <= {SW{`MCG_IDLE}};
    end else begin
      sync1_q <= raw_in; // R12
      sync2_q <= sync1_q; // R12
    end
  end

  assign pres_s = sync2_q[`MCG_SI_PRES +: 2];
  assign data_s = sync2_q[`MCG_SI_DATA +: 2];
  assign gp_s = sync2_q[`MCG_SI_GP +: GP_N];
  assign tx_low = {card2_tx_low, card1_tx_low};

  // Slot 2 is dead while assigned to the embedded card
  assign slot_act = {~ctrl_q[`MCG_CTRL_ESIM], 1'b1}; // R3

  // Inserted level follows polarity bit: 0 means low is inserted
  assign ins_now = pres_s ^ {2{~ctrl_q[`MCG_CTRL_POL]}}; // R2
  assign ins_ev = ins_now & ~ins_prev_q & slot_act; // R1
  assign rem_ev = ~ins_now & ins_prev_q & slot_act;

  // Previous inserted state for edge detection
  always @(posedge core_clk) begin
    if (reset) begin
      ins_prev_q <= 2'b00;
    end else begin
      ins_prev_q <= ins_now; // R1
    end
  end

  // Shared card clock divider; tick marks each half period
  always @(posedge core_clk) begin
    if (reset) begin
      div_q <= {DIV_W{1'b0}};
      tick_q <= 1'b0;
    end else if (div_q == CARD_CLK_DIV[DIV_W-1:0] - 1'b1) begin
      div_q <= {DIV_W{1'b0}};
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : g_slot
      reg clk_q;
      reg rst_n_q;
      reg d_out_q;
      reg d_oe_q;
      reg rx_q;
      // Card side pins; an idle slot holds clock and reset low
      always @(posedge core_clk) begin
        if (reset) begin
          clk_q <= 1'b0;
          rst_n_q <= 1'b0;
          d_out_q <= 1'b0;
          d_oe_q <= 1'b0;
          rx_q <= `MCG_IDLE;
        end else begin
          if (slot_act[s] && ctrl_q[`MCG_CTRL_CLK1 + s]) begin
            clk_q <= clk_q ^ tick_q; // R4
          end else begin
            clk_q <= 1'b0;
          end
          rst_n_q <= slot_act[s] & ctrl_q[`MCG_CTRL_RUN1 + s]; // R4
          // Data line is open drain over the card pull-up
          d_out_q <= 1'b0;
          d_oe_q <= slot_act[s] & tx_low[s]; // R4
          rx_q <= data_s[s] | ~slot_act[s];
        end
      end
      assign clk_w[s] = clk_q;
      assign rst_w[s] = rst_n_q;
      assign dout_w[s] = d_out_q;
      assign doe_w[s] = d_oe_q;
      assign rx_w[s] = rx_q;
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < GP_N; i = i + 1) begin : g_gp
      reg out_q;
      reg oe_q;
      reg alt_in_q;
      // Pin role decides who drives the pad
      always @(posedge core_clk) begin
        if (reset) begin
          out_q <= 1'b0;
          oe_q <= 1'b0;
          alt_in_q <= `MCG_IDLE;
        end else begin
          case (gp_role(gp_mode_q, i)) // R8
            `MCG_GP_OUT: begin
              out_q <= gp_level_q[i]; // R10
              oe_q <= 1'b1; // R11
            end
            `MCG_GP_ALT: begin
              out_q <= gp_alt_out[i];
              oe_q <= gp_alt_oe[i];
            end
            default: begin
              out_q <= 1'b0;
              oe_q <= 1'b0;
            end
          endcase
          alt_in_q <= gp_s[i];
        end
      end
      // Fast shutdown is requested by a low level on such a pin
      assign fsd_hit[i] = (gp_role(gp_mode_q, i) == `MCG_GP_FSD) & ~gp_s[i];
      assign gp_out_w[i] = out_q;
      assign gp_oe_w[i] = oe_q;
      assign gp_alt_in[i] = alt_in_q;
    end
  endgenerate

  // Wake sources gated by their enable bits
  assign wake_hits = {evt_voice, evt_dereg, evt_sms} & wake_en_q; // R6
  assign events = {|wake_hits, rem_ev, ins_ev};

  assign wr_ctrl = reg_wr && (reg_addr == `MCG_OFF_CTRL);
  assign wr_stat = reg_wr && (reg_addr == `MCG_OFF_INT_STAT);

  // Sticky status: write one clears, a new event in that cycle wins
  always @* begin
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_d & ~reg_wdata[`MCG_EV_W-1:0];
    end
    stat_d = stat_d | events;
  end

  // Software written registers
  always @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= `MCG_CTRL_RST;
      wake_en_q <= `MCG_WAKE_RST;
      mask_q <= `MCG_EV_RST;
      stat_q <= `MCG_EV_RST;
      gp_mode_q <= {GP_N{`MCG_GP_IN}};
      gp_level_q <= {GP_N{1'b0}};
    end else begin
      stat_q <= stat_d;
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata[`MCG_CTRL_W-1:0]; // R2
      end
      if (reg_wr && reg_addr == `MCG_OFF_WAKE_EN) begin
        wake_en_q <= reg_wdata[`MCG_WAKE_W-1:0];
      end
      if (reg_wr && reg_addr == `MCG_OFF_INT_MASK) begin
        mask_q <= reg_wdata[`MCG_EV_W-1:0];
      end
      if (reg_wr && reg_addr == `MCG_OFF_GP_MODE) begin
        gp_mode_q <= reg_wdata[2*GP_N-1:0]; // R8
      end
      if (reg_wr && reg_addr == `MCG_OFF_GP_OUT) begin
        gp_level_q <= reg_wdata[GP_N-1:0]; // R10
      end
    end
  end

  // Level outputs toward the modem core and host
  always @(posedge core_clk) begin
    if (reset) begin
      irq_q <= 1'b0;
      wake_n_q <= 1'b1;
      airplane_q <= 1'b0;
      gnss_off_q <= 1'b0;
      dpr_q <= 1'b0;
      fsd_q <= 1'b0;
    end else begin
      irq_q <= |(stat_d & mask_q);
      wake_n_q <= ~stat_d[`MCG_EV_WAKE]; // R6
      airplane_q <= ~sync2_q[`MCG_SI_RADIO]; // R5
      gnss_off_q <= ~sync2_q[`MCG_SI_GNSS]; // R5
      // Reduction policy itself is not defined; only the request is passed
      dpr_q <= ctrl_q[`MCG_CTRL_DPR_EN] & sync2_q[`MCG_SI_DPR]; // R7
      fsd_q <= |fsd_hit;
    end
  end

  assign pin_stat = {data_s, sync2_q[`MCG_SI_DPR], gnss_off_q, airplane_q,
                     ins_now};

  // Read mux; unmapped words read zero
  always @* begin
    rdata_d = 32'h00000000;
    case (reg_addr)
      `MCG_OFF_CTRL: rdata_d[`MCG_CTRL_W-1:0] = ctrl_q;
      `MCG_OFF_WAKE_EN: rdata_d[`MCG_WAKE_W-1:0] = wake_en_q;
      `MCG_OFF_INT_STAT: rdata_d[`MCG_EV_W-1:0] = stat_q;
      `MCG_OFF_INT_MASK: rdata_d[`MCG_EV_W-1:0] = mask_q;
      `MCG_OFF_PIN_STAT: rdata_d[`MCG_PS_W-1:0] = pin_stat;
      `MCG_OFF_GP_MODE: rdata_d[2*GP_N-1:0] = gp_mode_q;
      `MCG_OFF_GP_OUT: rdata_d[GP_N-1:0] = gp_level_q; // R10
      `MCG_OFF_GP_IN: rdata_d[GP_N-1:0] = gp_s; // R9
      default: rdata_d = 32'h00000000;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (reset) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq_out = irq_q;
  assign card1_clock_out = clk_w[0];
  assign card2_clock_out = clk_w[1];
  assign card1_reset_out_n = rst_w[0];
  assign card2_reset_out_n = rst_w[1];
  assign card1_data_out = dout_w[0];
  assign card2_data_out = dout_w[1];
  assign card1_data_oe = doe_w[0];
  assign card2_data_oe = doe_w[1];
  assign card1_rx_data = rx_w[0];
  assign card2_rx_data = rx_w[1];
  assign airplane_mode = airplane_q;
  assign positioning_off = gnss_off_q;
  assign tx_power_reduce = dpr_q;
  assign host_wake_out_n = wake_n_q;
  assign gp_out = gp_out_w;
  assign gp_oe = gp_oe_w;
  assign fast_shutdown = fsd_q;

endmodule // mcg_top

// *** mcg_regs.vh ***
`ifndef MCG_REGS_VH
`define MCG_REGS_VH

// Register word indices on the plain register port
`define MCG_AW 4
`define MCG_OFF_CTRL 4'h0
`define MCG_OFF_WAKE_EN 4'h1
`define MCG_OFF_INT_STAT 4'h2
`define MCG_OFF_INT_MASK 4'h3
`define MCG_OFF_PIN_STAT 4'h4
`define MCG_OFF_GP_MODE 4'h5
`define MCG_OFF_GP_OUT 4'h6
`define MCG_OFF_GP_IN 4'h7

// Control register fields
`define MCG_CTRL_W 7
`define MCG_CTRL_POL 0
`define MCG_CTRL_ESIM 1
`define MCG_CTRL_RUN1 2
`define MCG_CTRL_CLK1 4
`define MCG_CTRL_DPR_EN 6
`define MCG_CTRL_RST 7'h00

// Wake enable fields
`define MCG_WAKE_W 3
`define MCG_WAKE_SMS 0
`define MCG_WAKE_DEREG 1
`define MCG_WAKE_VOICE 2
`define MCG_WAKE_RST 3'h0

// Interrupt status / mask fields
`define MCG_EV_W 5
`define MCG_EV_INS 0
`define MCG_EV_REM 2
`define MCG_EV_WAKE 4
`define MCG_EV_RST 5'h00

// Pin status layout: {card data[1:0], dpr, gnss off, airplane, inserted[1:0]}
`define MCG_PS_W 7

// General purpose pin roles, two bits per pin
`define MCG_GP_IN 2'h0
`define MCG_GP_OUT 2'h1
`define MCG_GP_FSD 2'h2
`define MCG_GP_ALT 2'h3

// Synchroniser bit positions of the pin inputs
`define MCG_SI_PRES 0
`define MCG_SI_RADIO 2
`define MCG_SI_GNSS 3
`define MCG_SI_DPR 4
`define MCG_SI_DATA 5
`define MCG_SI_GP 7

// Idle level of pulled-up inputs, used as synchroniser reset value
`define MCG_IDLE 1'b1

`endif

// *** mcg_top_monitor.sv ***
`timescale 1ns/100ps
module mcg_top_monitor #(
  parameter GP_N = 9
) (
  input wire core_clk,
  input wire reset,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire evt_sms,
  input wire evt_dereg,
  input wire evt_voice,
  input wire host_wake_out_n,
  input wire radio_disable_in_n,
  input wire positioning_disable_in_n,
  input wire airplane_mode,
  input wire positioning_off,
  input wire power_reduce_in,
  input wire tx_power_reduce,
  input wire [GP_N-1:0] gp_in,
  input wire [GP_N-1:0] gp_alt_in,
  input wire fast_shutdown
);
  // One clock domain, so one clocking and one reset for all
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Wake falls one edge after the core event that is sampled with it
  a_wake_cause: assert property (
    $fell(host_wake_out_n) |-> $past(evt_sms | evt_dereg | evt_voice))
    else $error("wake without event");
  // Read data is zero outside the answer cycle
  a_rd_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
  a_rd_upper: assert property (
    $past(reg_rd) |-> reg_rdata[31:18] == 14'h0) else $error("upper bits");
  // Pins pass two sync stages and an output register
  a_air_level: assert property (
    airplane_mode == !$past(radio_disable_in_n, 3))
    else $error("airplane level");
  a_gnss_level: assert property (
    positioning_off == !$past(positioning_disable_in_n, 3))
    else $error("positioning level");
  a_power_cut: assert property (
    tx_power_reduce |-> $past(power_reduce_in, 3)) else $error("power cut");
  a_gp_sync: assert property (
    gp_alt_in == $past(gp_in, 3)) else $error("pin sync depth");
  a_fsd_pin: assert property (
    fast_shutdown |-> !(&$past(gp_in, 3))) else $error("shutdown cause");
endmodule // mcg_top_monitor

bind mcg_top mcg_top_monitor #(.GP_N(GP_N)) i_mon (.*);

// *** mcg_partner.sv ***
`timescale 1ns/100ps
module mcg_partner #(
  parameter GP_N = 9
) (
  input wire card1_data_oe,
  input wire card2_data_oe,
  input wire card_pull_low,
  output wire card1_data_in,
  output wire card2_data_in,
  input wire [GP_N-1:0] gp_out,
  input wire [GP_N-1:0] gp_oe,
  input wire [GP_N-1:0] ext_level,
  output wire [GP_N-1:0] gp_in
);
  // Card data is open drain with a pull-up; the card may pull low
  assign card1_data_in = !(card1_data_oe | card_pull_low);
  assign card2_data_in = !(card2_data_oe | card_pull_low);
  // Driven pins show the design level, others the board level
  assign gp_in = (gp_oe & gp_out) | (~gp_oe & ext_level);
endmodule // mcg_partner

// *** module_control_and_gpio_pins_tb_top.sv ***
`timescale 1ns/100ps
`include "mcg_regs.vh"
module module_control_and_gpio_pins_tb_top;
  localparam GP_N = 9;
  reg core_clk, reset, reg_wr, reg_rd;
  reg [3:0] reg_addr;
  reg [31:0] reg_wdata;
  reg card1_present_in, card2_present_in, card1_tx_low, card2_tx_low;
  reg radio_disable_in_n, positioning_disable_in_n, power_reduce_in;
  reg evt_sms, evt_dereg, evt_voice, card_pull_low;
  reg [GP_N-1:0] gp_alt_out, gp_alt_oe, ext_level;
  wire [31:0] reg_rdata;
  wire irq_out, card1_clock_out, card2_clock_out, card1_reset_out_n;
  wire card2_reset_out_n, card1_data_in, card2_data_in, card1_data_out;
  wire card2_data_out, card1_data_oe, card2_data_oe, card1_rx_data;
  wire card2_rx_data, airplane_mode, positioning_off, tx_power_reduce;
  wire host_wake_out_n, fast_shutdown;
  wire [GP_N-1:0] gp_in, gp_out, gp_oe, gp_alt_in;
  integer bad_count, total_checks, seed, i;
  reg [31:0] rv, ck;
  mcg_top #(.GP_N(GP_N)) i_dut (.*);
  mcg_partner #(.GP_N(GP_N)) i_far (.*);
  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    bad_count = bad_count + 1;
    test_done;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
    end
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input [3:0] a);
    begin
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
    end
  endtask
  task rc(input [3:0] a, input [31:0] e);
    begin
      rd(a);
      chk(rv, e);
    end
  endtask
  task pulse(input [2:0] e);
    begin
      @(posedge core_clk);
      {evt_voice, evt_dereg, evt_sms} <= e;
      @(posedge core_clk);
      {evt_voice, evt_dereg, evt_sms} <= 3'h0;
    end
  endtask
  task test_done;
    begin
      $display("checks %0d bad %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Main sequence; pins idle high except power_reduce_in, so the other synchronisers agree at release
  initial begin
    bad_count = 0;
    total_checks = 0;
    seed = 32'h3CA3;
    {reset, reg_wr, reg_rd} = 3'h4;
    {reg_addr, reg_wdata} = 36'h0;
    {card1_present_in, card2_present_in} = 2'h3;
    {radio_disable_in_n, positioning_disable_in_n} = 2'h3;
    {power_reduce_in, card1_tx_low, card2_tx_low, card_pull_low} = 4'h0;
    {evt_sms, evt_dereg, evt_voice} = 3'h0;
    {gp_alt_out, gp_alt_oe} = 18'h0;
    ext_level = 9'h1FF;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    rc(`MCG_OFF_CTRL, 32'h0);
    rc(4'h9, 32'h0);
    chk(host_wake_out_n, 32'h1);
    $display("reset test ended");
    wr(`MCG_OFF_INT_MASK, 32'h1F);
    card1_present_in <= 1'b0;
    tick(4);
    rc(`MCG_OFF_INT_STAT, 32'h1);
    chk(irq_out, 32'h1);
    wr(`MCG_OFF_INT_STAT, 32'h1);
    card1_present_in <= 1'b1;
    tick(4);
    rc(`MCG_OFF_INT_STAT, 32'h4);
    wr(`MCG_OFF_INT_STAT, 32'h4);
    wr(`MCG_OFF_CTRL, 32'h1);
    tick(4);
    rc(`MCG_OFF_INT_STAT, 32'h3);
    wr(`MCG_OFF_INT_STAT, 32'h3);
    card1_present_in <= 1'b0;
    tick(4);
    rc(`MCG_OFF_INT_STAT, 32'h4);
    wr(`MCG_OFF_INT_STAT, 32'h4);
    tick(2);
    chk(irq_out, 32'h0);
    $display("presence test ended");
    // Slot two as embedded: its pins and events are ignored
    wr(`MCG_OFF_CTRL, 32'h3F);
    card2_present_in <= 1'b0;
    card1_tx_low <= 1'b1;
    card2_tx_low <= 1'b1;
    tick(4);
    rc(`MCG_OFF_INT_STAT, 32'h0);
    chk({card2_reset_out_n, card1_reset_out_n}, 32'h1);
    chk({card2_data_oe, card1_data_oe}, 32'h1);
    chk({card2_data_out, card2_rx_data, card1_rx_data, card1_data_out},
        32'h4);
    ck = card1_clock_out;
    tick(4);
    chk(card1_clock_out, ~ck & 32'h1);
    chk(card2_clock_out, 32'h0);
    card1_tx_low <= 1'b0;
    card2_tx_low <= 1'b0;
    $display("card test ended");
    // Each wake source: ignored when off, wakes when on
    for (i = 0; i < 3; i = i + 1) begin
      wr(`MCG_OFF_WAKE_EN, 32'h7 ^ (32'h1 << i));
      pulse(3'h1 << i);
      tick(2);
      chk(host_wake_out_n, 32'h1);
      wr(`MCG_OFF_WAKE_EN, 32'h1 << i);
      pulse(3'h1 << i);
      tick(2);
      chk({irq_out, host_wake_out_n}, 32'h2);
      rc(`MCG_OFF_INT_STAT, 32'h10);
      wr(`MCG_OFF_INT_STAT, 32'h10);
      tick(2);
      chk({irq_out, host_wake_out_n}, 32'h1);
    end
    wr(`MCG_OFF_INT_MASK, 32'h0);
    pulse(3'h4);
    tick(2);
    chk({irq_out, host_wake_out_n}, 32'h0);
    wr(`MCG_OFF_INT_STAT, 32'h10);
    $display("wake test ended");
    {radio_disable_in_n, positioning_disable_in_n} <= 2'h0;
    power_reduce_in <= 1'b1;
    wr(`MCG_OFF_CTRL, 32'h7F);
    tick(4);
    chk({airplane_mode, positioning_off, tx_power_reduce}, 32'h7);
    rd(`MCG_OFF_PIN_STAT);
    chk(rv[4:2], 32'h7);
    {radio_disable_in_n, positioning_disable_in_n} <= 2'h3;
    power_reduce_in <= 1'b0;
    tick(4);
    chk({airplane_mode, positioning_off, tx_power_reduce}, 32'h0);
    $display("control test ended");
    // Output, input and alternate roles with random levels; shutdown role with pin 0 low
    rv = $random(seed);
    ck = rv & 32'h1FF;
    wr(`MCG_OFF_GP_MODE, 32'h15555);
    wr(`MCG_OFF_GP_OUT, rv);
    tick(4);
    chk({gp_oe, gp_out}, {14'h0, 9'h1FF, ck[8:0]});
    rc(`MCG_OFF_GP_OUT, ck);
    rc(`MCG_OFF_GP_IN, ck);
    rv = $random(seed);
    ext_level <= rv[8:0];
    wr(`MCG_OFF_GP_MODE, 32'h0);
    wr(`MCG_OFF_GP_IN, ~rv);
    tick(4);
    chk(gp_oe, 32'h0);
    rc(`MCG_OFF_GP_IN, rv & 32'h1FF);
    ext_level <= 9'h1FE;
    wr(`MCG_OFF_GP_MODE, 32'h2);
    tick(4);
    chk(fast_shutdown, 32'h1);
    rv = $random(seed);
    {gp_alt_out, gp_alt_oe} <= rv[17:0];
    wr(`MCG_OFF_GP_MODE, 32'h3FFFF);
    tick(3);
    chk({gp_out, gp_oe}, rv & 32'h3FFFF);
    $display("pin test ended");
    test_done;
  end
endmodule // module_control_and_gpio_pins_tb_top
